// ---- two_wire_register_access_port_bench.sv ----
`timescale 1ns/1ps

module two_wire_register_access_port_bench;
  // arbitrary target address
  localparam logic [6:0] ADDR = 7'h2A;
  logic clk = 1'b0;
  logic lclk = 1'b0;
  logic nrst = 1'b0;
  logic strap = 1'b0;
  wire logic scl;
  wire logic sda_low;
  wire logic sda_o;
  wire logic oe;
  wire logic ready;
  wire logic we;
  wire logic [5:0] cfg_addr;
  wire logic [7:0] cfg_data;
  wire logic sda;
  int mismatches = 0;
  int samples_checked = 0;
  int cyc = 0;
  logic [5:0] idx;
  logic [31:0] st = 32'h00008967;
  logic [7:0] mem [64];
  logic [13:0] expq [$];
  assign sda = ~(sda_low | oe);
  always #5 clk = ~clk;
  always #6 lclk = ~lclk;
  twr_port #(.POR_CYCLES(70), .DEV_ADDR(ADDR)) DUT (
    .i_clk(clk), .i_nrst(nrst), .i_scl(scl), .i_sda(sda), .o_sda_o(sda_o), .o_sda_oe(oe),
    .i_bus_address_select_pin(strap), .o_ready(ready), .o_cfg_we(we),
    .o_cfg_addr(cfg_addr), .o_cfg_data(cfg_data));
  twr_master_model m (.i_lclk(lclk), .i_sda(sda), .o_scl(scl), .o_sda_low(sda_low));
  function automatic logic [31:0] xs();
    st = st ^ (st << 13);
    st = st ^ (st >> 17);
    st = st ^ (st << 5);
    return st;
  endfunction
  task automatic chk(input logic [13:0] got, input logic [13:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(negedge clk)
  begin
    if (we === 1'b1)
      chk({cfg_addr, cfg_data}, expq.size() ? expq.pop_front() : 14'hxxxx);
  end
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      mismatches++;
      final_report();
    end
  end
  task automatic wr(input logic [5:0] at, input int n);
    logic a;
    logic [7:0] d;
    m.start();
    m.wbyte({ADDR[6:1], strap, 1'b0}, a);
    chk(a, 0);
    m.wbyte({2'h0, at}, a);
    chk(a, 0);
    idx = at;
    repeat (n)
    begin
      d = 8'(xs());
      expq.push_back({idx, d});
      mem[idx] = d;
      m.wbyte(d, a);
      chk(a, 0);
      idx = {idx[5:4], idx[3:0] + 4'h1};
    end
    m.stop();
  endtask
  task automatic rd(input logic [5:0] at, input int n);
    logic a;
    logic [7:0] q;
    m.start();
    m.wbyte({ADDR[6:1], strap, 1'b0}, a);
    m.wbyte({2'h0, at}, a);
    idx = at;
    m.start();
    m.wbyte({ADDR[6:1], strap, 1'b1}, a);
    chk(a, 0);
    for (int i = 1; i <= n; i++)
    begin
      m.rbyte(i == n, q);
      chk(q, mem[idx]);
      idx = {idx[5:4], idx[3:0] + 4'h1};
    end
    m.stop();
  endtask
  initial
  begin
    logic a;
    logic [31:0] r;
    r = xs();
    for (int i = 0; i < 64; i++)
    begin
      expq.push_back({i[5:0], 8'h00});
      mem[i] = 8'h00;
    end
    @(posedge clk);
    strap <= r[0];
    repeat (15) @(posedge clk);
    nrst <= 1'b1;
    repeat (200) if (ready !== 1'b1) @(negedge clk);
    chk(ready, 1);
    chk(expq.size(), 0);
    $display("test power-on done");
    m.start();
    m.wbyte({ADDR[6:1], ~strap, 1'b0}, a);
    chk(a, 1);
    m.stop();
    $display("test foreign address done");
    rd(6'h05, 1);
    $display("test default read done");
    for (int g = 0; g < 4; g++)
    begin
      wr({g[1:0], 4'hE}, 3);
      rd({g[1:0], 4'hE}, 3);
      $display("test group %0d done", g);
    end
    chk(expq.size(), 0);
    final_report();
  end
endmodule

// ---- twr_defines.svh ----
`ifndef TWR_DEFINES_SVH
`define TWR_DEFINES_SVH

// clock period of the system domain
`define TWR_CLK_PERIOD_NS 10
// register space
`define TWR_NUM_REGS 64
`define TWR_IDX_W 6
`define TWR_DATA_W 8
`define TWR_NIB_W 4
// power-on reset hold time and its cycle count (rounded up)
`define TWR_POR_TIME_NS 2000
`define TWR_POR_CYCLES ((`TWR_POR_TIME_NS + `TWR_CLK_PERIOD_NS - 1) / `TWR_CLK_PERIOD_NS)
`define TWR_POR_CNT_W 16
// serial target address, strap-selected bit position
`define TWR_DEV_ADDR 7'h2A
`define TWR_ADDR_SEL_BIT 0
// direction bit values
`define TWR_DIR_READ 1'b1
`define TWR_DIR_WRITE 1'b0
// default byte of every register
`define TWR_REG_DEFAULT 8'h00
// synchroniser lanes: scl, sda, strap, link toggle
`define TWR_SYNC_LANES 4
`define TWR_LANE_SCL 0
`define TWR_LANE_SDA 1
`define TWR_LANE_STRAP 2
`define TWR_LANE_TOG 3
// last bit index of a byte
`define TWR_LAST_BIT 4'h7

`endif

// ---- twr_master_model.sv ----
`timescale 1ns/1ps

module twr_master_model (
  input wire logic i_lclk,
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda_low
);
  initial
  begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end
  task automatic ph();
    repeat (8) @(posedge i_lclk);
  endtask
  task automatic start();
    o_sda_low <= 1'b0;
    ph();
    o_scl <= 1'b1;
    ph();
    o_sda_low <= 1'b1;
    ph();
    o_scl <= 1'b0;
    ph();
  endtask
  task automatic stop();
    o_sda_low <= 1'b1;
    ph();
    o_scl <= 1'b1;
    ph();
    o_sda_low <= 1'b0;
    ph();
  endtask
  task automatic bitx(input logic b, output logic r);
    o_sda_low <= ~b;
    ph();
    o_scl <= 1'b1;
    ph();
    r = i_sda;
    o_scl <= 1'b0;
    ph();
  endtask
  task automatic xfer(input logic [7:0] d, output logic [7:0] q);
    for (int i = 7; i >= 0; i--)
      bitx(d[i], q[i]);
  endtask
  task automatic wbyte(input logic [7:0] d, output logic ack_n);
    logic [7:0] q;
    xfer(d, q);
    bitx(1'b1, ack_n);
  endtask
  // master acks read bytes, nacks the last
  task automatic rbyte(input logic nack, output logic [7:0] q);
    logic r;
    xfer(8'hFF, q);
    bitx(nack, r);
  endtask
endmodule

// ---- twr_pkg.sv ----
package twr_pkg;

  typedef enum logic [8:0] {
    TWR_ST_IDLE  = 9'h001,
    TWR_ST_ADDR  = 9'h002,
    TWR_ST_AACK  = 9'h004,
    TWR_ST_INDEX = 9'h008,
    TWR_ST_IACK  = 9'h010,
    TWR_ST_WDATA = 9'h020,
    TWR_ST_WACK  = 9'h040,
    TWR_ST_RDATA = 9'h080,
    TWR_ST_RACK  = 9'h100
  } twr_state_t;

endpackage

// ---- twr_port.sv ----
// Operation
// - every serial byte moves most significant bit first, least significant bit last.
// - one target address bit takes the level of the address-select strap pin at the end of power-on reset, then holds it.
// - after each data byte the low four bits of the register index advance by one.
// - the upper two index bits never take a carry and keep the value the master wrote.
// - the port runs its own power-on reset sequence once the external i_nrst reset pin is released.
// - once power-on reset completes, every register holds its default value.
// - each transaction opens with a start and closes with a stop from the master.
// - on writes the master sends data and the port acks; on reads the roles swap.
`include "twr_defines.svh"
`timescale 1ns/1ps

module twr_port
  import twr_pkg::*;
#(
  parameter int POR_CYCLES = `TWR_POR_CYCLES,
  parameter logic [6:0] DEV_ADDR = `TWR_DEV_ADDR,
  parameter logic [`TWR_NUM_REGS*`TWR_DATA_W-1:0] DEFAULTS =
    {`TWR_NUM_REGS{`TWR_REG_DEFAULT}}
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_o,
  output logic o_sda_oe,
  input wire logic i_bus_address_select_pin,
  output logic o_ready,
  output logic o_cfg_we,
  output logic [`TWR_IDX_W-1:0] o_cfg_addr,
  output logic [`TWR_DATA_W-1:0] o_cfg_data
);

  // refuse a count that cannot cover the default load
  if (POR_CYCLES < `TWR_NUM_REGS || POR_CYCLES >= (1 << `TWR_POR_CNT_W))
  begin : g_bad_por
    $error("twr_port: power-on reset count out of range");
  end

  // low nibble increment without carry
  function automatic logic [`TWR_IDX_W-1:0] next_index(input logic [`TWR_IDX_W-1:0] idx);
    logic [`TWR_NIB_W-1:0] nib;
    nib = idx[`TWR_NIB_W-1:0] + 4'h1;
    return {idx[`TWR_IDX_W-1:`TWR_NIB_W], nib};
  endfunction

  // link clock domain: bit capture on rising scl
  logic link_tog;
  logic link_bit;

  always_ff @(posedge i_scl or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      link_tog <= 1'b0;
      link_bit <= 1'b0;
    end
    else
    begin
      link_tog <= ~link_tog;
      link_bit <= i_sda;
    end
  end

  // two-flop synchronisers into the system clock
  logic [`TWR_SYNC_LANES-1:0] sync_in;
  logic [`TWR_SYNC_LANES-1:0] sync1;
  logic [`TWR_SYNC_LANES-1:0] sync2;
  // idle levels: lines high, link toggle low
  localparam logic [`TWR_SYNC_LANES-1:0] SYNC_IDLE = 4'h7;

  assign sync_in = {link_tog, i_bus_address_select_pin, i_sda, i_scl};

  genvar g;
  generate
    for (g = 0; g < `TWR_SYNC_LANES; g++)
    begin : g_sync
      always_ff @(posedge i_clk or negedge i_nrst)
      begin
        if (!i_nrst)
        begin
          sync1[g] <= SYNC_IDLE[g];
          sync2[g] <= SYNC_IDLE[g];
        end
        else
        begin
          sync1[g] <= sync_in[g];
          sync2[g] <= sync1[g];
        end
      end
    end
  endgenerate

  logic scl_q;
  logic sda_q;
  logic tog_q;

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      tog_q <= 1'b0;
    end
    else
    begin
      scl_q <= sync2[`TWR_LANE_SCL];
      sda_q <= sync2[`TWR_LANE_SDA];
      tog_q <= sync2[`TWR_LANE_TOG];
    end
  end

  // power-on reset sequence
  logic [`TWR_POR_CNT_W-1:0] por_cnt;
  logic por_busy;
  logic por_fill;
  logic adr_sel;

  assign por_busy = (por_cnt != POR_CYCLES[`TWR_POR_CNT_W-1:0]);
  assign por_fill = (por_cnt < `TWR_NUM_REGS);

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      por_cnt <= '0;
    end
    else if (por_busy)
    begin
      por_cnt <= por_cnt + 16'h0001;
    end
  end

  // strap caught at end of reset
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      adr_sel <= 1'b0;
    end
    else if (por_busy)
    begin
      adr_sel <= sync2[`TWR_LANE_STRAP];
    end
  end

  // bus events
  logic scl_hi;
  logic start_ev;
  logic stop_ev;
  logic fall_ev;
  logic bit_ev;
  logic [6:0] my_addr;

  assign scl_hi = sync2[`TWR_LANE_SCL] & scl_q;
  assign start_ev = scl_hi & sda_q & ~sync2[`TWR_LANE_SDA];
  assign stop_ev = scl_hi & ~sda_q & sync2[`TWR_LANE_SDA];
  assign fall_ev = scl_q & ~sync2[`TWR_LANE_SCL];
  assign bit_ev = tog_q ^ sync2[`TWR_LANE_TOG];
  assign my_addr = {DEV_ADDR[6:1], adr_sel};

  // protocol engine
  twr_state_t state;
  logic [3:0] cnt;
  logic [7:0] shreg;
  logic [7:0] tx;
  logic [`TWR_IDX_W-1:0] index;
  logic rw;
  logic ack_on;
  logic byte_end;
  logic [7:0] byte_in;
  logic wr_fire;
  logic [`TWR_DATA_W-1:0] rd_data;

  assign byte_in = {shreg[6:0], link_bit};
  assign byte_end = bit_ev && (cnt == `TWR_LAST_BIT);
  assign wr_fire = (state == TWR_ST_WDATA) && byte_end;

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      state <= TWR_ST_IDLE;
      cnt <= 4'h0;
      shreg <= 8'h00;
      tx <= 8'h00;
      index <= '0;
      rw <= 1'b0;
      ack_on <= 1'b0;
      o_sda_oe <= 1'b0;
    end
    else if (por_busy || stop_ev)
    begin
      state <= TWR_ST_IDLE;
      ack_on <= 1'b0;
      o_sda_oe <= 1'b0;
    end
    else if (start_ev)
    begin
      state <= TWR_ST_ADDR;
      cnt <= 4'h0;
      ack_on <= 1'b0;
      o_sda_oe <= 1'b0;
    end
    else
    begin
      case (state)
        TWR_ST_IDLE:
        begin
          o_sda_oe <= 1'b0;
        end
        TWR_ST_ADDR, TWR_ST_INDEX, TWR_ST_WDATA:
        begin
          if (bit_ev)
          begin
            shreg <= byte_in;
            cnt <= cnt + 4'h1;
          end
          if (byte_end && state == TWR_ST_ADDR)
          begin
            // direction bit, 1 read and 0 write
            rw <= (link_bit == `TWR_DIR_READ);
            state <= (shreg[6:0] == my_addr) ? TWR_ST_AACK : TWR_ST_IDLE;
          end
          else if (byte_end && state == TWR_ST_INDEX)
          begin
            index <= byte_in[`TWR_IDX_W-1:0];
            state <= TWR_ST_IACK;
          end
          else if (byte_end)
          begin
            index <= next_index(index);
            state <= TWR_ST_WACK;
          end
        end
        TWR_ST_AACK, TWR_ST_IACK, TWR_ST_WACK:
        begin
          // port acks address and written bytes
          if (fall_ev && !ack_on)
          begin
            ack_on <= 1'b1;
            o_sda_oe <= 1'b1;
          end
          else if (fall_ev)
          begin
            ack_on <= 1'b0;
            cnt <= 4'h0;
            if (state == TWR_ST_AACK && rw)
            begin
              tx <= {rd_data[6:0], 1'b0};
              o_sda_oe <= ~rd_data[7];
              state <= TWR_ST_RDATA;
            end
            else
            begin
              o_sda_oe <= 1'b0;
              state <= (state == TWR_ST_AACK) ? TWR_ST_INDEX : TWR_ST_WDATA;
            end
          end
        end
        TWR_ST_RDATA:
        begin
          // read data shifted out top bit first
          if (bit_ev)
          begin
            cnt <= cnt + 4'h1;
          end
          if (byte_end)
          begin
            state <= TWR_ST_RACK;
          end
          else if (fall_ev)
          begin
            o_sda_oe <= ~tx[7];
            tx <= {tx[6:0], 1'b0};
          end
        end
        TWR_ST_RACK:
        begin
          if (fall_ev && !ack_on)
          begin
            o_sda_oe <= 1'b0;
          end
          else if (bit_ev)
          begin
            ack_on <= 1'b1;
            rw <= ~link_bit;
            index <= next_index(index);
          end
          else if (fall_ev && rw)
          begin
            ack_on <= 1'b0;
            cnt <= 4'h0;
            tx <= {rd_data[6:0], 1'b0};
            o_sda_oe <= ~rd_data[7];
            state <= TWR_ST_RDATA;
          end
          else if (fall_ev)
          begin
            ack_on <= 1'b0;
            state <= TWR_ST_IDLE;
          end
        end
        default:
        begin
          state <= TWR_ST_IDLE;
        end
      endcase
    end
  end

  // register storage write and read selection
  logic mem_we;
  logic [`TWR_IDX_W-1:0] mem_waddr;
  logic [`TWR_DATA_W-1:0] mem_wdata;

  assign mem_we = por_busy ? por_fill : wr_fire;
  assign mem_waddr = por_busy ? por_cnt[`TWR_IDX_W-1:0] : index;
  assign mem_wdata = por_busy ? DEFAULTS[por_cnt[`TWR_IDX_W-1:0]*`TWR_DATA_W +: `TWR_DATA_W]
                              : byte_in;

  twr_regmem #(
    .WIDTH(`TWR_DATA_W),
    .DEPTH(`TWR_NUM_REGS),
    .AW(`TWR_IDX_W)
  ) u_mem (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_we(mem_we),
    .i_waddr(mem_waddr),
    .i_wdata(mem_wdata),
    .i_raddr(index),
    .o_rdata(rd_data)
  );

  // configuration update strobe to the core
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_cfg_we <= 1'b0;
      o_cfg_addr <= '0;
      o_cfg_data <= '0;
      o_ready <= 1'b0;
    end
    else
    begin
      o_cfg_we <= mem_we;
      o_cfg_addr <= mem_waddr;
      o_cfg_data <= mem_wdata;
      o_ready <= ~por_busy;
    end
  end

  // open-drain: only ever pulls low
  assign o_sda_o = 1'b0;

endmodule

// ---- twr_port_assertions.sv ----
`timescale 1ns/1ps

module twr_port_assertions #(
  parameter int POR_CYCLES = 200
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic o_sda_o,
  input wire logic o_sda_oe,
  input wire logic o_ready,
  input wire logic o_cfg_we,
  input wire logic [5:0] o_cfg_addr,
  input wire logic [7:0] o_cfg_data
);
  default clocking @(posedge i_clk);
  endclocking
  default disable iff (!i_nrst);
  logic sda_q;
  logic have_prev;
  logic [5:0] prev;
  logic [15:0] por_cnt;
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      sda_q <= 1'b1;
      have_prev <= 1'b0;
      prev <= 6'h00;
      por_cnt <= 16'h0000;
    end
    else
    begin
      sda_q <= i_sda;
      por_cnt <= por_cnt + {15'h0000, ~&por_cnt};
      if (o_cfg_we)
        prev <= o_cfg_addr;
      if (i_scl && sda_q && !i_sda)
        have_prev <= 1'b0;
      else if (o_cfg_we && o_ready)
        have_prev <= 1'b1;
    end
  end
  sequence s_start;
    i_scl && sda_q && !i_sda;
  endsequence
  sequence s_pulse;
    o_cfg_we ##1 !o_cfg_we;
  endsequence
  a_quiet_before_ready: assert property (!o_ready |-> !o_sda_oe)
    else $error("sda driven before ready");
  a_ready_after_por: assert property (o_ready |-> por_cnt >= POR_CYCLES)
    else $error("ready too early");
  a_ready_stays: assert property (o_ready |=> o_ready)
    else $error("ready dropped");
  a_open_drain: assert property (o_sda_o == 1'b0)
    else $error("sda output not low");
  a_default_zero: assert property (!o_ready && o_cfg_we |-> o_cfg_data == 8'h00)
    else $error("default byte wrong");
  a_default_order: assert property (
    !o_ready && o_cfg_we && $past(o_cfg_we) |-> o_cfg_addr == $past(o_cfg_addr) + 6'h01)
    else $error("default load order wrong");
  a_write_single: assert property (o_ready && o_cfg_we |-> s_pulse)
    else $error("write strobe too long");
  a_index_step: assert property (
    o_ready && o_cfg_we && have_prev |-> o_cfg_addr == {prev[5:4], prev[3:0] + 4'h1})
    else $error("index step wrong");
  a_steady_scl_high: assert property (i_scl && $past(i_scl) |-> $stable(o_sda_oe))
    else $error("sda changed while scl high");
  a_free_at_start: assert property (s_start |-> !o_sda_oe)
    else $error("sda held at start");
endmodule

bind twr_port twr_port_assertions #(.POR_CYCLES(POR_CYCLES)) u_chk (
  .i_clk(i_clk), .i_nrst(i_nrst), .i_scl(i_scl), .i_sda(i_sda), .o_sda_o(o_sda_o),
  .o_sda_oe(o_sda_oe), .o_ready(o_ready), .o_cfg_we(o_cfg_we), .o_cfg_addr(o_cfg_addr),
  .o_cfg_data(o_cfg_data));

// ---- twr_regmem.sv ----
`timescale 1ns/1ps

module twr_regmem #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 64,
  parameter int AW = 6
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_we,
  input wire logic [AW-1:0] i_waddr,
  input wire logic [WIDTH-1:0] i_wdata,
  input wire logic [AW-1:0] i_raddr,
  output logic [WIDTH-1:0] o_rdata
);

  logic [WIDTH-1:0] mem [DEPTH];

  if (DEPTH > (1 << AW))
  begin : g_bad_depth
    $error("twr_regmem: depth exceeds address range");
  end

  // write port, no reset on the array
  always_ff @(posedge i_clk)
  begin
    if (i_we)
    begin
      mem[i_waddr] <= i_wdata;
    end
  end

  // registered read port
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_rdata <= '0;
    end
    else
    begin
      o_rdata <= mem[i_raddr];
    end
  end

endmodule
